//--- dasm_defs.svh
// Purpose: constants for the disc address and sector match block
// Assumes: word-indexed Avalon-MM slave, 16-bit host word in writedata[15:0]
// Notes: host_bus_bit n is writedata[15-n]
`ifndef DASM_DEFS_SVH
`define DASM_DEFS_SVH

// register word indexes (byte offset = index * 4)
`define DASM_IDX_ADDR 3'h0
`define DASM_IDX_SUB 3'h1
`define DASM_IDX_CFG 3'h2
`define DASM_IDX_STAT 3'h3
`define DASM_IDX_POS 3'h4

// host word field positions
`define DASM_SECT_LSB 0
`define DASM_SECT_MSB 4
`define DASM_TRK_LSB 5
`define DASM_TRK_MSB 11
`define DASM_UNIT_LSB 12
`define DASM_UNIT_MSB 13
`define DASM_SUB_LSB 12
`define DASM_SUB_MSB 15

// config field positions and reset value
`define DASM_CFG_TRK_LSB 0
`define DASM_CFG_TRK_MSB 1
`define DASM_CFG_IL_LSB 2
`define DASM_CFG_IL_MSB 3
`define DASM_CFG_RESET 4'h0

// highest track before the unit carry, per track count selection
`define DASM_TRK_LAST_128 9'h07F
`define DASM_TRK_LAST_256 9'h0FF
`define DASM_TRK_LAST_512 9'h1FF

// last subsector slot of a track and of a sector
`define DASM_LAST_SECT 5'h1F
`define DASM_LAST_SUB 4'hF
`define DASM_SUBS_LAST_OP 5'h0F

`endif

//--- dasm_pkg.sv
// Purpose: types for the disc address and sector match block
// Assumes: nothing beyond dasm_defs.svh
// Notes: state record is registered as a whole
package dasm_pkg;
    typedef struct packed {
        logic to_s1;
        logic to_s2;
        logic to_d;
        logic sy_s1;
        logic sy_s2;
        logic sy_d;
        logic rdy_s1;
        logic rdy_s2;
        logic pc_d;
        logic [3:0] subsector;
        logic [4:0] sector;
        logic [8:0] track;
        logic [1:0] unit;
        logic [1:0] unit_prev;
        logic sub_mode;
        logic [1:0] cfg_trk;
        logic [1:0] cfg_il;
        logic [11:0] pos;
        logic pend;
        logic hold_off;
        logic chg_flag;
        logic en;
        logic match;
        logic head;
        logic done;
        logic [4:0] ops;
        logic ack;
        logic [31:0] rdata;
    } dasm_state_type;
endpackage

//--- dasm_core.sv
// Purpose: disc unit/track/sector address register and sector match
// Assumes: drive pins are asynchronous, parity_cycle_flag_i is same-clock
// Notes: one cycle of waitrequest on every access
`timescale 1ns/1ns
`default_nettype none
`include "dasm_defs.svh"

// Notes on behaviour
// - with chained drives, track wrap to zero bumps the unit address
// - unit carry happens at a selectable track count of 128, 256 or 512
// - after an automatic unit change, one track-origin period passes before matching
// - any unit address change pulses unit change and clears match enable
// - address load captures host bits 11..15 as start sector
// - subsector load captures host bits 0..3 as start subsector
// - subsector/sector counter advances when the parity cycle flag clears
// - last sector sets pending; track advances at origin rise; origin fall clears
// - head-switch notice on track advance, address load and reset
// - without subsector load, one operation is 16 subsectors
// - address load captures host bits 4..10 as track, driven to the drive
// - track at maximum when origin deasserts sets unit-change flag, clears enable
// - 12-bit position counter cleared by active-low track origin
// - position counter steps on trailing edge of subsector sync (pin returning high)
// - a track is 32 sectors of 16 subsectors
// - in whole-sector operation only the five sector bits are compared
// - compare against position with interlace 1:1, 2:1, 4:1 or 8:1
// - match in both polarities when all bits agree and enable is set
// - enable cleared on drive not ready, unit change or reset
// - address load captures host bits 2,3 as unit, one select line low
module dasm_core (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    // avalon-mm slave
    input wire logic [2:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    // drive side
    input wire logic track_origin_n_i,
    input wire logic subsector_sync_n_i,
    input wire logic drive_ready_flag_i,
    output logic [3:0] drive_select_n_o,
    output logic [8:0] track_line_o,
    output logic head_switch_n_o,
    // transfer control side
    input wire logic parity_cycle_flag_i,
    output logic sector_match_o,
    output logic sector_match_n_o,
    output logic op_done_o
);
    import dasm_pkg::*;

    dasm_state_type s;
    dasm_state_type next_s;
    logic to_rise;
    logic to_fall;
    logic sy_end;
    logic pc_end;
    logic req;
    logic take;
    logic wr_addr;
    logic wr_sub;
    logic wr_cfg;
    logic unit_chg;
    logic at_last;
    logic cmp_eq;
    logic [8:0] routed;

    // counter bit routing for the wired interlace
    function automatic logic [8:0] route_pos(input logic [11:0] p, input logic [1:0] il);
        case (il)
            2'h0: route_pos = p[8:0];
            2'h1: route_pos = {p[0], p[8:1]};
            2'h2: route_pos = {p[1:0], p[8:2]};
            default: route_pos = {p[2:0], p[8:3]};
        endcase
    endfunction

    function automatic logic [8:0] trk_last(input logic [1:0] sel);
        case (sel)
            2'h0: trk_last = `DASM_TRK_LAST_128;
            2'h1: trk_last = `DASM_TRK_LAST_256;
            default: trk_last = `DASM_TRK_LAST_512;
        endcase
    endfunction

    // origin is true while the pin is low
    assign to_rise = s.to_d & ~s.to_s2;
    assign to_fall = ~s.to_d & s.to_s2;
    assign sy_end = ~s.sy_d & s.sy_s2;
    assign pc_end = s.pc_d & ~parity_cycle_flag_i;
    assign req = avs_read_i | avs_write_i;
    assign take = req & s.ack;
    assign wr_addr = avs_write_i & take & (avs_address_i == `DASM_IDX_ADDR)
        & (avs_byteenable_i[1:0] == 2'h3);
    assign wr_sub = avs_write_i & take & (avs_address_i == `DASM_IDX_SUB)
        & avs_byteenable_i[1];
    assign wr_cfg = avs_write_i & take & (avs_address_i == `DASM_IDX_CFG)
        & avs_byteenable_i[0];
    assign unit_chg = s.unit != s.unit_prev;
    assign at_last = (s.track == trk_last(s.cfg_trk));
    assign routed = route_pos(s.pos, s.cfg_il);
    // whole-sector mode leaves subsector bits out of the compare
    assign cmp_eq = (routed[8:4] == s.sector)
        & (~s.sub_mode | (routed[3:0] == s.subsector));

    always_comb begin
        next_s = s;
        // two-flop synchronisers, first stage read only by the second
        next_s.to_s1 = track_origin_n_i;
        next_s.to_s2 = s.to_s1;
        next_s.to_d = s.to_s2;
        next_s.sy_s1 = subsector_sync_n_i;
        next_s.sy_s2 = s.sy_s1;
        next_s.sy_d = s.sy_s2;
        next_s.rdy_s1 = drive_ready_flag_i;
        next_s.rdy_s2 = s.rdy_s1;
        next_s.pc_d = parity_cycle_flag_i;
        next_s.unit_prev = s.unit;
        next_s.head = 1'b0;

        // bus: one wait cycle, read data latched on the first cycle
        next_s.ack = req & ~s.ack;
        if (avs_read_i & ~s.ack) begin
            case (avs_address_i)
                `DASM_IDX_CFG: next_s.rdata = {28'h0, s.cfg_il, s.cfg_trk};
                `DASM_IDX_STAT: next_s.rdata = {6'h0, s.rdy_s2, s.pend, s.done,
                    s.sub_mode, s.en, s.match, s.unit, s.track, s.sector, s.subsector};
                `DASM_IDX_POS: next_s.rdata = {11'h0, routed, s.pos};
                default: next_s.rdata = 32'h0;
            endcase
        end
        if (wr_cfg) begin
            next_s.cfg_trk = avs_writedata_i[`DASM_CFG_TRK_MSB:`DASM_CFG_TRK_LSB];
            next_s.cfg_il = avs_writedata_i[`DASM_CFG_IL_MSB:`DASM_CFG_IL_LSB];
        end

        // position counter held clear while origin is true
        if (~s.to_s2) begin
            next_s.pos = 12'h000;
        end else if (sy_end) begin
            next_s.pos = 12'(s.pos + 12'h001);
        end

        // subsector address steps at the end of each subsector
        if (pc_end) begin
            {next_s.sector, next_s.subsector} = 9'({s.sector, s.subsector} + 9'h001);
            // 32 sectors of 16 subsectors per track
            if (s.sector == `DASM_LAST_SECT && s.subsector == `DASM_LAST_SUB) begin
                next_s.pend = 1'b1;
            end
            if (~s.sub_mode & ~s.done) begin
                next_s.ops = 5'(s.ops + 5'h01);
                if (s.ops == `DASM_SUBS_LAST_OP) begin
                    next_s.done = 1'b1;
                end
            end
        end

        // track advance at origin rise; wrap carries into the unit
        if (to_rise) begin
            next_s.chg_flag = 1'b0;
            if (s.pend) begin
                next_s.head = 1'b1;
                if (at_last) begin
                    next_s.track = 9'h000;
                    next_s.unit = 2'(s.unit + 2'h1);
                end else begin
                    next_s.track = 9'(s.track + 9'h001);
                end
            end
        end
        // pending clears at origin fall unless a new end of track lands now
        if (to_fall & ~(pc_end & s.sector == `DASM_LAST_SECT
                & s.subsector == `DASM_LAST_SUB)) begin
            next_s.pend = 1'b0;
        end
        if (to_fall & at_last) begin
            next_s.chg_flag = 1'b1;
        end

        // match enable: armed at origin rise, one period lost after unit change
        if (to_rise) begin
            if (s.hold_off) begin
                next_s.hold_off = 1'b0;
            end else begin
                next_s.en = 1'b1;
            end
        end
        if (unit_chg) begin
            next_s.hold_off = 1'b1;
        end
        // clears win over the arm, as the flop's reset dominates
        if (~s.rdy_s2 | unit_chg | s.chg_flag | (to_fall & at_last)) begin
            next_s.en = 1'b0;
        end
        next_s.match = cmp_eq & s.en;

        // start address loads; processor keeps them stable during a transfer
        if (wr_addr) begin
            next_s.sector = avs_writedata_i[`DASM_SECT_MSB:`DASM_SECT_LSB];
            next_s.track = {2'h0, avs_writedata_i[`DASM_TRK_MSB:`DASM_TRK_LSB]};
            next_s.unit = avs_writedata_i[`DASM_UNIT_MSB:`DASM_UNIT_LSB];
            next_s.subsector = 4'h0;
            next_s.sub_mode = 1'b0;
            next_s.head = 1'b1;
            next_s.pend = 1'b0;
            next_s.done = 1'b0;
            next_s.ops = 5'h00;
        end
        if (wr_sub) begin
            next_s.subsector = avs_writedata_i[`DASM_SUB_MSB:`DASM_SUB_LSB];
            next_s.sub_mode = 1'b1;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            s <= '0;
            s.to_s1 <= 1'b1;
            s.to_s2 <= 1'b1;
            s.to_d <= 1'b1;
            s.sy_s1 <= 1'b1;
            s.sy_s2 <= 1'b1;
            s.sy_d <= 1'b1;
            s.cfg_trk <= 2'(`DASM_CFG_RESET >> `DASM_CFG_TRK_LSB);
            s.head <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    assign avs_waitrequest_o = req & ~s.ack;
    assign avs_readdata_o = s.rdata;
    assign track_line_o = s.track;
    assign head_switch_n_o = ~s.head;
    assign sector_match_o = s.match;
    assign sector_match_n_o = ~s.match;
    assign op_done_o = s.done;
    generate
        for (genvar g = 0; g < 4; g++) begin : g_sel
            assign drive_select_n_o[g] = ~(s.unit == 2'(g));
        end
    endgenerate

    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!rst_n_i);

    a_unit_carry: assert property (to_rise && s.pend && at_last && !wr_addr |=>
        s.track == 9'h000 && s.unit == 2'($past(s.unit) + 2'h1))
        else $error("unit carry missing at track wrap");
    a_track_step: assert property (to_rise && s.pend && !at_last && !wr_addr |=>
        s.track == 9'($past(s.track) + 9'h001) && s.head)
        else $error("track did not advance with head notice");
    a_match_gate: assert property (s.match |-> $past(s.en) && $past(cmp_eq))
        else $error("match without enable or equality");
    a_match_pol: assert property (sector_match_o == ~sector_match_n_o)
        else $error("match polarities disagree");
    a_not_ready: assert property (!s.rdy_s2 |=> !s.en ##1 !s.match)
        else $error("enable survived drive not ready");
    a_unit_hold: assert property (unit_chg |=> !s.en && s.hold_off)
        else $error("unit change did not clear enable");
    a_hold_period: assert property (s.hold_off && to_rise && !unit_chg |=> !s.en)
        else $error("match armed inside hold-off period");
    a_load_cap: assert property (wr_addr |=>
        s.sector == $past(avs_writedata_i[4:0]) && s.track[6:0] == $past(avs_writedata_i[11:5])
        && s.unit == $past(avs_writedata_i[13:12]) && !head_switch_n_o)
        else $error("address load not captured");
    a_pos_clear: assert property (!s.to_s2 |=> s.pos == 12'h000)
        else $error("position not cleared at origin");
    a_pos_step: assert property (s.to_s2 && sy_end |=> s.pos == 12'($past(s.pos) + 12'h001))
        else $error("position did not step on sync");
    a_sub_step: assert property (pc_end && !wr_addr && !wr_sub |=>
        {s.sector, s.subsector} == 9'($past({s.sector, s.subsector}) + 9'h001))
        else $error("subsector address did not advance");
    a_one_sector: assert property ($rose(s.done) |-> $past(s.ops) == 5'h0F && !s.sub_mode)
        else $error("operation length not one sector");
    a_sel_onehot: assert property ($onehot(~drive_select_n_o))
        else $error("drive select not one-hot");

    // load side: what address, subsector and configuration writes leave behind
    a_head_load: assert property (wr_addr |=>
        !head_switch_n_o)
        else $error("no head notice after address load");

    a_sub_load: assert property (wr_sub |=>
        s.sub_mode && s.subsector == $past(avs_writedata_i[15:12]))
        else $error("subsector load not captured");

    a_load_whole: assert property (wr_addr |=>
        !s.sub_mode && s.subsector == 4'h0)
        else $error("address load left subsector mode set");

    a_done_clear: assert property (wr_addr |=>
        !s.done && s.ops == 5'h00)
        else $error("address load did not restart the operation");

    a_trk_upper: assert property (wr_addr |=>
        s.track[8:7] == 2'h0)
        else $error("track load left upper bits set");

    a_mode_hold: assert property (!wr_addr && !wr_sub |=>
        s.sub_mode == $past(s.sub_mode))
        else $error("subsector mode changed without a load");

    a_cfg_hold: assert property (!wr_cfg |=>
        s.cfg_trk == $past(s.cfg_trk) && s.cfg_il == $past(s.cfg_il))
        else $error("configuration changed without a write");

    // address counters move only on their own events
    a_track_hold: assert property (!to_rise && !wr_addr |=>
        s.track == $past(s.track))
        else $error("track moved without origin or load");

    a_unit_steady: assert property (!to_rise && !wr_addr |=>
        s.unit == $past(s.unit))
        else $error("unit moved without carry or load");

    a_sect_hold: assert property (!pc_end && !wr_addr |=>
        s.sector == $past(s.sector))
        else $error("sector moved without subsector end");

    a_ops_count: assert property (pc_end && !s.sub_mode && !s.done && !wr_addr |=>
        s.ops == 5'($past(s.ops) + 5'h01))
        else $error("operation length counter did not step");

    a_pend_set: assert property (pc_end && s.sector == 5'h1F && s.subsector == 4'hF
        && !wr_addr |=> s.pend)
        else $error("pending not set at end of track");

    a_pend_clear: assert property (to_fall && !pc_end |=>
        !s.pend)
        else $error("pending survived origin fall");

    a_head_idle: assert property (!wr_addr && !(to_rise && s.pend) |=>
        head_switch_n_o)
        else $error("head notice without track advance or load");

    // position counter
    a_pos_hold: assert property (s.to_s2 && !sy_end |=>
        s.pos == $past(s.pos))
        else $error("position moved without sync");

    a_il_route: assert property (s.cfg_il == 2'h0 |->
        routed == s.pos[8:0])
        else $error("one to one interlace not straight through");

    // match enable and match
    a_chg_set: assert property (to_fall && at_last |=>
        s.chg_flag && !s.en)
        else $error("unit-change flag not set at last track");

    a_chg_clear: assert property (to_rise |=>
        !s.chg_flag)
        else $error("unit-change flag survived origin");

    a_hold_keep: assert property (s.hold_off && !to_rise |=>
        s.hold_off)
        else $error("hold-off ended before an origin");

    a_en_arm: assert property (to_rise && !s.hold_off && s.rdy_s2 && !unit_chg
        && !s.chg_flag |=> s.en)
        else $error("enable not armed at origin");

    a_en_keep: assert property (s.en && s.rdy_s2 && !unit_chg && !s.chg_flag
        && !(to_fall && at_last) |=> s.en)
        else $error("enable dropped without cause");

    a_match_clear: assert property (!s.en |=>
        !s.match)
        else $error("match raised while disabled");

    a_match_set: assert property (s.en && cmp_eq |=>
        s.match)
        else $error("match missing on equal address");

    a_whole_cmp: assert property (!s.sub_mode && s.en && routed[8:4] == s.sector |=>
        s.match)
        else $error("subsector bits took part in whole-sector match");
endmodule // dasm_core

`default_nettype wire

//--- dasm_drive_model.sv
// Purpose: behavioural disc drive for the address and sector match bench
// Assumes: tasks are entered just after a rising clock edge
// Notes: sync stands high outside revolutions; head notices are counted
`timescale 1ns/1ns
`default_nettype none
module dasm_drive_model (
    // clock
    input wire logic ref_clk_i,
    // from the controller
    input wire logic head_switch_n_i,
    // to the controller
    output logic track_origin_n_o,
    output logic subsector_sync_n_o,
    output logic drive_ready_flag_o
);
    int heads = 0;
    logic head_d = 1'b1;

    initial begin
        track_origin_n_o = 1'b1;
        subsector_sync_n_o = 1'b1;
        drive_ready_flag_o = 1'b1;
    end

    // one count per falling edge of the notice
    always @(posedge ref_clk_i) begin
        head_d <= head_switch_n_i;
        if (!head_switch_n_i && head_d) begin
            heads <= heads + 1;
        end
    end

    // origin held low long enough to pass the synchronisers
    task automatic origin();
        repeat (2) @(posedge ref_clk_i);
        track_origin_n_o <= 1'b0;
        repeat (8) @(posedge ref_clk_i);
        track_origin_n_o <= 1'b1;
        repeat (8) @(posedge ref_clk_i);
    endtask

    // gap sets how slowly subsectors pass under the head
    task automatic syncs(input int n, input int gap);
        repeat (n) begin
            subsector_sync_n_o <= 1'b0;
            repeat (3) @(posedge ref_clk_i);
            subsector_sync_n_o <= 1'b1;
            repeat (gap) @(posedge ref_clk_i);
        end
        repeat (4) @(posedge ref_clk_i);
    endtask

    task automatic set_ready(input logic v);
        drive_ready_flag_o <= v;
    endtask
endmodule // dasm_drive_model
`default_nettype wire

//--- dasm_core_tb_top.sv
// Purpose: self-checking bench for dasm_core
// Assumes: dasm_drive_model plays the drives
// Notes: waitrequest sampled at the rising edge that takes the access
`timescale 1ns/1ns
`default_nettype none
module dasm_core_tb_top;
    logic ref_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [2:0] adr = 3'h0;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic pcf = 1'b0;
    logic [31:0] wd = 32'h0;
    logic [3:0] be = 4'h0;
    logic [31:0] rdat, q;
    logic [3:0] sel_n;
    logic [8:0] trk;
    logic wait_o, to_n, sy_n, rdy, head_n, m, m_n, done;
    int err_total = 0;
    int checks = 0;
    int cyc = 0;
    int h0;

    always #2 ref_clk_i = ~ref_clk_i;

    dasm_core DUT (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .avs_address_i(adr),
        .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(be),
        .avs_readdata_o(rdat), .avs_waitrequest_o(wait_o), .track_origin_n_i(to_n),
        .subsector_sync_n_i(sy_n), .drive_ready_flag_i(rdy), .drive_select_n_o(sel_n),
        .track_line_o(trk), .head_switch_n_o(head_n), .parity_cycle_flag_i(pcf),
        .sector_match_o(m), .sector_match_n_o(m_n), .op_done_o(done));

    dasm_drive_model drv (.ref_clk_i(ref_clk_i), .head_switch_n_i(head_n),
        .track_origin_n_o(to_n), .subsector_sync_n_o(sy_n), .drive_ready_flag_o(rdy));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // one access; read data lands in q
    task automatic bus(input logic [2:0] a, input logic w, input logic [31:0] d,
        input logic [3:0] b);
        adr <= a;
        wr <= w;
        rd <= !w;
        wd <= d;
        be <= b;
        // taken at the edge that sees waitrequest low, data read there too
        @(posedge ref_clk_i iff !wait_o);
        q = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
        @(posedge ref_clk_i);
    endtask

    // address loaded before any transfer starts
    task automatic ld(input logic [1:0] u, input logic [6:0] t, input logic [4:0] s);
        bus(3'h0, 1'b1, {18'h0, u, t, s}, 4'hF);
    endtask

    task automatic par(input int n);
        repeat (n) begin
            pcf <= 1'b1;
            repeat (2) @(posedge ref_clk_i);
            pcf <= 1'b0;
            repeat (2) @(posedge ref_clk_i);
        end
    endtask

    task automatic done_test(input string name);
        $display("test %s done", name);
    endtask

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // hang guard, well above the few thousand cycles the tests need
    always @(posedge ref_clk_i) begin
        cyc++;
        if (cyc == 30000) begin
            err_total++;
            finish_test();
        end
    end

    initial begin
        repeat (6) @(posedge ref_clk_i);
        rst_n_i <= 1'b1;
        @(posedge ref_clk_i);
        chk(sel_n, 4'hE);
        chk({m, m_n, done}, 3'b010);
        bus(3'h2, 1'b0, 32'h0, 4'h0);
        chk(q, 32'h0);
        bus(3'h3, 1'b0, 32'h0, 4'h0);
        chk(q, 32'h0200_0000);
        bus(3'h2, 1'b1, 32'hF, 4'h2);
        bus(3'h2, 1'b0, 32'h0, 4'h0);
        chk(q, 32'h0);
        bus(3'h6, 1'b1, 32'hFFFF, 4'hF);
        bus(3'h5, 1'b0, 32'h0, 4'h0);
        chk(q, 32'h0);
        done_test("reset");
        for (int u = 0; u < 4; u++) begin
            h0 = drv.heads;
            ld(u[1:0], 7'h40 + 7'(u), 5'h15 - 5'(u));
            chk(sel_n ^ 4'hF, 1 << u);
            chk(trk, 7'h40 + u);
            bus(3'h3, 1'b0, 32'h0, 4'h0);
            chk(q[8:0], {5'h15 - 5'(u), 4'h0});
            chk(drv.heads, h0 + 1);
        end
        // last load changed the unit: first origin is lost to the hold-off
        drv.origin();
        drv.origin();
        bus(3'h3, 1'b0, 32'h0, 4'h0);
        chk(q[21], 1'b1);
        ld(2'h2, 7'h03, 5'h01);
        bus(3'h3, 1'b0, 32'h0, 4'h0);
        chk(q[21], 1'b0);
        drv.origin();
        drv.origin();
        drv.set_ready(1'b0);
        repeat (6) @(posedge ref_clk_i);
        bus(3'h3, 1'b0, 32'h0, 4'h0);
        chk({q[25], q[21]}, 2'b00);
        drv.set_ready(1'b1);
        done_test("load");
        for (int il = 0; il < 4; il++) begin
            bus(3'h2, 1'b1, il << 2, 4'h1);
            ld(2'h2, 7'h03, 5'h01);
            drv.origin();
            bus(3'h4, 1'b0, 32'h0, 4'h0);
            chk(q[11:0], 12'h0);
            drv.syncs((16 << il) - 1, 3 + 2 * il);
            bus(3'h4, 1'b0, 32'h0, 4'h0);
            chk(q[11:0], (16 << il) - 1);
            chk(m, 1'b0);
            drv.syncs(1, 3);
            chk({m, m_n}, 2'b10);
        end
        bus(3'h2, 1'b1, 32'h0, 4'h1);
        bus(3'h1, 1'b1, 32'h2000, 4'h2);
        bus(3'h3, 1'b0, 32'h0, 4'h0);
        chk({q[22], q[3:0]}, 5'h12);
        drv.origin();
        drv.syncs(17, 3);
        chk(m, 1'b0);
        drv.syncs(1, 3);
        chk(m, 1'b1);
        ld(2'h2, 7'h03, 5'h01);
        repeat (3) @(posedge ref_clk_i);
        chk(m, 1'b1);
        done_test("match");
        ld(2'h2, 7'h0A, 5'h1F);
        par(15);
        bus(3'h3, 1'b0, 32'h0, 4'h0);
        chk({q[24:23], q[8:0]}, {2'b00, 5'h1F, 4'hF});
        par(1);
        bus(3'h3, 1'b0, 32'h0, 4'h0);
        chk({q[23], q[8:0]}, 10'h200);
        chk(q[24], 1'b1);
        h0 = drv.heads;
        drv.origin();
        chk(trk, 9'h00B);
        chk(drv.heads, h0 + 1);
        bus(3'h3, 1'b0, 32'h0, 4'h0);
        chk(q[24], 1'b0);
        done_test("advance");
        for (int c = 1; c < 4; c++) begin
            bus(3'h2, 1'b1, c, 4'h1);
            ld(2'h2, 7'h7F, 5'h1F);
            par(16);
            drv.origin();
            chk({sel_n, trk}, {4'hB, 9'h080});
        end
        bus(3'h2, 1'b1, 32'h0, 4'h1);
        ld(2'h2, 7'h7F, 5'h1F);
        drv.origin();
        bus(3'h3, 1'b0, 32'h0, 4'h0);
        chk(q[21], 1'b0);
        par(16);
        drv.origin();
        chk({sel_n, trk}, {4'h7, 9'h000});
        bus(3'h3, 1'b0, 32'h0, 4'h0);
        chk(q[21], 1'b0);
        drv.origin();
        drv.origin();
        bus(3'h3, 1'b0, 32'h0, 4'h0);
        chk(q[21], 1'b1);
        done_test("carry");
        finish_test();
    end
endmodule // dasm_core_tb_top
`default_nettype wire
